/* mnso_pkg.sv */
// Operation
// - literal multiply puts W times literal into product pair, high byte high.
// - multiplies change only the product pair, never W or the source byte.
// - register multiply puts W times data byte into product pair in one cycle.
// - bank bit 0 uses access bank; 1 uses the bank select register.
// - multiplies leave every status flag untouched, zero included.
// - negate writes two's complement back and updates N, OV, C, DC, Z.
// - pop discards the stack top in one cycle, flags untouched.
// - push stores program counter plus two as new top in one cycle.
// - relative call takes an 11-bit signed offset and pushes PC plus two.
// - relative call then loads PC plus two plus 2n; second cycle idles.
// - software reset returns W, bank select, PC, stack pointer, product, flags, instruction and memory address to reset values.
package mnso_pkg;

  localparam int STACK_DEPTH = 31;
  localparam int PTR_W = 5;
  localparam int PC_W = 21;

  // apb register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_INSTR = 8'h04;
  localparam logic [7:0] OFF_WREG = 8'h08;
  localparam logic [7:0] OFF_BANK = 8'h0C;
  localparam logic [7:0] OFF_PROD = 8'h10;
  localparam logic [7:0] OFF_STATUS = 8'h14;
  localparam logic [7:0] OFF_PC = 8'h18;
  localparam logic [7:0] OFF_STACK_TOP = 8'h1C;
  localparam logic [7:0] OFF_SP = 8'h20;
  localparam logic [7:0] OFF_MEM_ADDR = 8'h24;
  localparam logic [7:0] OFF_MEM_DATA = 8'h28;

  // control bit: writing 1 to bit 0 of ctrl starts one instruction
  localparam int CTRL_GO_BIT = 0;
  localparam int CTRL_BUSY_BIT = 1;

  // status flag positions
  localparam int FLAG_C = 0;
  localparam int FLAG_DC = 1;
  localparam int FLAG_Z = 2;
  localparam int FLAG_OV = 3;
  localparam int FLAG_N = 4;

  // opcode patterns
  localparam logic [7:0] OPC_MUL_LIT = 8'h0D;
  localparam logic [6:0] OPC_MUL_REG = 7'h01;
  localparam logic [6:0] OPC_NEG = 7'h36;
  localparam logic [4:0] OPC_REL_CALL = 5'h1B;
  localparam logic [15:0] OPC_POP = 16'h0006;
  localparam logic [15:0] OPC_PUSH = 16'h0005;
  localparam logic [15:0] OPC_RESET = 16'h00FF;
  localparam logic [15:0] OPC_NOP0 = 16'h0000;
  localparam logic [3:0] OPC_NOP_HI = 4'hF;

  // reset values and access bank split
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [PC_W-1:0] RST_PC = 21'h000000;
  localparam logic [7:0] ACCESS_SPLIT = 8'h60;
  localparam logic [3:0] ACCESS_HI_BANK = 4'hF;

  // relative call idles one more instruction cycle of four clocks
  localparam logic [1:0] CALL_IDLE_LAST = 2'h3;

  typedef enum logic [3:0] {
    OP_NOP, OP_MUL_LIT, OP_MUL_REG, OP_NEG, OP_POP, OP_PUSH,
    OP_REL_CALL, OP_RESET, OP_ILLEGAL
  } mnso_op_t;

  typedef struct packed {
    logic paddr_ok;
    logic [7:0] paddr;
    logic pwrite;
    logic [31:0] pwdata;
  } mnso_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } mnso_apb_rsp_t;

endpackage

/* mnso_core.sv */
`timescale 1ns/10ps
module mnso_core (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  output logic [31:0] o_prdata,
  output logic o_pready,
  output logic o_pslverr,
  output logic [mnso_pkg::PC_W-1:0] o_pc,
  output logic [15:0] o_product,
  output logic o_busy
);
  import mnso_pkg::*;

  typedef enum {PH_IDLE, PH_DECODE, PH_READ, PH_PROC, PH_WRITE, PH_IDLE2}
    mnso_phase_t;

  logic [15:0] instr_reg;
  logic [7:0] wreg_reg;
  logic [3:0] bank_select_register_reg;
  logic [7:0] product_high_byte_reg;
  logic [7:0] product_low_byte_reg;
  logic [4:0] flags_reg;
  logic [PC_W-1:0] pc_reg;
  logic [PC_W-1:0] stack_mem [STACK_DEPTH];
  logic [PTR_W-1:0] sp_reg;
  logic [7:0] data_mem [4096];
  logic [11:0] mem_addr_reg;
  mnso_phase_t phase_reg;
  mnso_op_t op_reg;
  logic [7:0] operand_reg;
  logic [11:0] ea_reg;
  logic [7:0] result_reg;
  logic [15:0] prod_calc_reg;
  logic [4:0] flags_calc_reg;
  logic sw_reset;
  logic go;
  logic apb_wr;
  logic apb_access;
  logic [PC_W-1:0] return_stack_top;
  logic [8:0] neg_sum;
  logic [4:0] neg_low;
  mnso_apb_req_t apb_req;
  mnso_apb_rsp_t rsp_next;

  // decode one instruction word into an operation class
  function automatic mnso_op_t decode_op(input logic [15:0] w);
    mnso_op_t r;
    r = OP_ILLEGAL;
    if (w == OPC_NOP0 || w[15:12] == OPC_NOP_HI) begin
      r = OP_NOP;
    end else if (w == OPC_POP) begin
      r = OP_POP;
    end else if (w == OPC_PUSH) begin
      r = OP_PUSH;
    end else if (w == OPC_RESET) begin
      r = OP_RESET;
    end else if (w[15:8] == OPC_MUL_LIT) begin
      r = OP_MUL_LIT;
    end else if (w[15:9] == OPC_MUL_REG) begin
      r = OP_MUL_REG;
    end else if (w[15:9] == OPC_NEG) begin
      r = OP_NEG;
    end else if (w[15:11] == OPC_REL_CALL) begin
      r = OP_REL_CALL;
    end
    return r;
  endfunction

  // effective data address; access bank splits low ram and high sfrs
  function automatic logic [11:0] eff_addr(input logic a,
      input logic [7:0] f, input logic [3:0] bank);
    logic [11:0] r;
    r = {bank, f};
    if (!a) begin
      r = (f < ACCESS_SPLIT) ? {4'h0, f} : {ACCESS_HI_BANK, f};
    end
    return r;
  endfunction

  // write strobe for one register word, only on the edge that samples ready
  function automatic logic wr_hit(input logic wr, input logic [7:0] ad,
      input logic [7:0] off);
    return wr && ad == off;
  endfunction

  // empty stack reads as the reset address instead of a stale entry
  assign return_stack_top = (sp_reg == '0) ? RST_PC :
    stack_mem[sp_reg - 5'h01];

  // request bundle; a write lands once, at the edge where ready is seen
  assign apb_req.paddr_ok = i_paddr[1:0] == 2'h0 && i_paddr <= OFF_MEM_DATA;
  assign apb_req.paddr = i_paddr;
  assign apb_req.pwrite = i_pwrite;
  assign apb_req.pwdata = i_pwdata;
  assign apb_access = i_psel && i_penable && o_pready;
  assign apb_wr = apb_access && apb_req.pwrite && apb_req.paddr_ok;
  assign go = wr_hit(apb_wr, apb_req.paddr, OFF_CTRL) &&
    apb_req.pwdata[CTRL_GO_BIT] && phase_reg == PH_IDLE;
  assign sw_reset = phase_reg == PH_WRITE && op_reg == OP_RESET;

  // negation worked out once; the carry out flags a zero operand
  assign neg_sum = {1'h0, ~operand_reg} + 9'h001;
  assign neg_low = {1'h0, ~operand_reg[3:0]} + 5'h01;

  // four-phase sequencer; relative call adds an idle cycle of four phases
  logic [1:0] idle_cnt_reg;
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      phase_reg <= PH_IDLE;
      idle_cnt_reg <= 2'd0;
    end else begin
      case (phase_reg)
        PH_IDLE: begin
          if (go) begin
            phase_reg <= PH_DECODE;
          end
        end
        PH_DECODE: phase_reg <= PH_READ;
        PH_READ: phase_reg <= PH_PROC;
        PH_PROC: phase_reg <= PH_WRITE;
        PH_WRITE: begin
          if (op_reg == OP_REL_CALL) begin
            phase_reg <= PH_IDLE2;
            idle_cnt_reg <= 2'h0;
          end else begin
            phase_reg <= PH_IDLE;
          end
        end
        PH_IDLE2: begin
          idle_cnt_reg <= idle_cnt_reg + 2'h1;
          if (idle_cnt_reg == CALL_IDLE_LAST) begin
            phase_reg <= PH_IDLE;
          end
        end
        default: phase_reg <= PH_IDLE;
      endcase
    end
  end

  // decode phase: classify and form the effective address
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      op_reg <= OP_NOP;
      ea_reg <= 12'h000;
    end else if (phase_reg == PH_DECODE) begin
      op_reg <= decode_op(instr_reg);
      ea_reg <= eff_addr(instr_reg[8], instr_reg[7:0],
        bank_select_register_reg);
    end
  end

  // read phase: literal or data byte
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      operand_reg <= RST_BYTE;
    end else if (phase_reg == PH_READ) begin
      if (op_reg == OP_MUL_LIT) begin
        operand_reg <= instr_reg[7:0];
      end else begin
        operand_reg <= data_mem[ea_reg];
      end
    end
  end

  // process phase: product and negation with its flags
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      prod_calc_reg <= 16'h0000;
      result_reg <= RST_BYTE;
      flags_calc_reg <= 5'h00;
    end else if (phase_reg == PH_PROC) begin
      prod_calc_reg <= wreg_reg * operand_reg;
      result_reg <= neg_sum[7:0];
      flags_calc_reg[FLAG_C] <= neg_sum[8];
      flags_calc_reg[FLAG_DC] <= neg_low[4];
      flags_calc_reg[FLAG_Z] <= neg_sum[7:0] == 8'h00;
      flags_calc_reg[FLAG_N] <= neg_sum[7];
      flags_calc_reg[FLAG_OV] <= operand_reg == 8'h80;
    end
  end

  // product pair written only by the multiplies and cleared by software reset, flags kept
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || sw_reset) begin
      product_high_byte_reg <= RST_BYTE;
      product_low_byte_reg <= RST_BYTE;
    end else if (phase_reg == PH_WRITE &&
        (op_reg == OP_MUL_LIT || op_reg == OP_MUL_REG)) begin
      product_high_byte_reg <= prod_calc_reg[15:8];
      product_low_byte_reg <= prod_calc_reg[7:0];
    end
  end

  // status flags change only on negate or software reset; software may preset them
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || sw_reset) begin
      flags_reg <= 5'h00;
    end else if (phase_reg == PH_WRITE && op_reg == OP_NEG) begin
      flags_reg <= flags_calc_reg;
    end else if (wr_hit(apb_wr, apb_req.paddr, OFF_STATUS)) begin
      flags_reg <= i_pwdata[4:0];
    end
  end

  // data memory: negate writes back, software loads through a window
  always_ff @(posedge i_ref_clk) begin
    if (phase_reg == PH_WRITE && op_reg == OP_NEG) begin
      data_mem[ea_reg] <= result_reg;
    end else if (wr_hit(apb_wr, apb_req.paddr, OFF_MEM_DATA)) begin
      data_mem[mem_addr_reg] <= i_pwdata[7:0];
    end
  end

  // return stack; push/call write, pop only moves the pointer
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || sw_reset) begin
      sp_reg <= '0;
    end else if (phase_reg == PH_READ &&
        (op_reg == OP_PUSH || op_reg == OP_REL_CALL)) begin
      if (sp_reg != PTR_W'(STACK_DEPTH)) begin
        stack_mem[sp_reg] <= pc_reg + PC_W'(2);
        sp_reg <= sp_reg + 5'd1;
      end
    end else if (phase_reg == PH_PROC && op_reg == OP_POP) begin
      if (sp_reg != '0) begin
        sp_reg <= sp_reg - 5'd1;
      end
    end
  end

  // program counter: advances one word, call adds the doubled offset
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || sw_reset) begin
      pc_reg <= RST_PC;
    end else if (phase_reg == PH_WRITE && op_reg == OP_REL_CALL) begin
      pc_reg <= pc_reg + PC_W'(2) +
        {{(PC_W-12){instr_reg[10]}}, instr_reg[10:0], 1'b0};
    end else if (phase_reg == PH_WRITE) begin
      pc_reg <= pc_reg + PC_W'(2);
    end else if (wr_hit(apb_wr, apb_req.paddr, OFF_PC) &&
        phase_reg == PH_IDLE) begin
      pc_reg <= i_pwdata[PC_W-1:0];
    end
  end

  // software-loaded registers; w survives every op here except software reset, which clears it
  always_ff @(posedge i_ref_clk) begin
    if (i_rst || sw_reset) begin
      wreg_reg <= RST_BYTE;
      bank_select_register_reg <= 4'h0;
      mem_addr_reg <= 12'h000;
      instr_reg <= OPC_NOP0;
    end else if (apb_wr && phase_reg == PH_IDLE) begin
      if (i_paddr == OFF_INSTR) begin
        instr_reg <= i_pwdata[15:0];
      end else if (i_paddr == OFF_WREG) begin
        wreg_reg <= i_pwdata[7:0];
      end else if (i_paddr == OFF_BANK) begin
        bank_select_register_reg <= i_pwdata[3:0];
      end else if (i_paddr == OFF_MEM_ADDR) begin
        mem_addr_reg <= i_pwdata[11:0];
      end
    end
  end

  // read mux; registering it below gives the single wait state
  always_comb begin
    rsp_next.prdata = 32'h0000_0000;
    rsp_next.pready = 1'h1;
    rsp_next.pslverr = 1'h0;
    if (apb_req.paddr == OFF_CTRL) begin
      rsp_next.prdata = 32'(phase_reg != PH_IDLE) << CTRL_BUSY_BIT;
    end else if (apb_req.paddr == OFF_INSTR) begin
      rsp_next.prdata = {16'h0000, instr_reg};
    end else if (apb_req.paddr == OFF_WREG) begin
      rsp_next.prdata = {24'h000000, wreg_reg};
    end else if (apb_req.paddr == OFF_BANK) begin
      rsp_next.prdata = {28'h0000000, bank_select_register_reg};
    end else if (apb_req.paddr == OFF_PROD) begin
      rsp_next.prdata = {16'h0000, product_high_byte_reg,
        product_low_byte_reg};
    end else if (apb_req.paddr == OFF_STATUS) begin
      rsp_next.prdata = {27'h0000000, flags_reg};
    end else if (apb_req.paddr == OFF_PC) begin
      rsp_next.prdata = {11'h000, pc_reg};
    end else if (apb_req.paddr == OFF_STACK_TOP) begin
      rsp_next.prdata = {11'h000, return_stack_top};
    end else if (apb_req.paddr == OFF_SP) begin
      rsp_next.prdata = {27'h0000000, sp_reg};
    end else if (apb_req.paddr == OFF_MEM_ADDR) begin
      rsp_next.prdata = {20'h00000, mem_addr_reg};
    end else if (apb_req.paddr == OFF_MEM_DATA) begin
      rsp_next.prdata = {24'h000000, data_mem[mem_addr_reg]};
    end else begin
      rsp_next.pslverr = 1'h1; // unmapped or unaligned address
    end
  end

  // apb answer: ready and error stand for exactly one cycle; data holds until the next answer
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pready <= 1'h0;
      o_prdata <= 32'h0000_0000;
      o_pslverr <= 1'h0;
    end else if (i_psel && i_penable && !o_pready) begin
      o_pready <= rsp_next.pready;
      o_prdata <= rsp_next.prdata;
      o_pslverr <= rsp_next.pslverr;
    end else begin
      o_pready <= 1'b0;
      o_pslverr <= 1'b0;
    end
  end

  // program counter seen outside, one cycle behind the core copy
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_pc <= RST_PC;
    end else begin
      o_pc <= pc_reg;
    end
  end

  // product pair seen outside, high byte on top
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_product <= 16'h0000;
    end else begin
      o_product <= {product_high_byte_reg, product_low_byte_reg};
    end
  end

  // busy rises with the start strobe so software never sees a gap
  always_ff @(posedge i_ref_clk) begin
    if (i_rst) begin
      o_busy <= 1'h0;
    end else begin
      o_busy <= phase_reg != PH_IDLE || go;
    end
  end

endmodule // mnso_core

/* mnso_checker.sv */
`timescale 1ns/10ps
module mnso_checker (
  input wire logic i_ref_clk,
  input wire logic i_rst,
  input wire logic i_psel,
  input wire logic i_penable,
  input wire logic i_pwrite,
  input wire logic [7:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  input wire logic o_pready,
  input wire logic o_pslverr,
  input wire logic [mnso_pkg::PC_W-1:0] o_pc,
  input wire logic [15:0] o_product,
  input wire logic o_busy
);
  import mnso_pkg::*;
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  // access phase still waiting for its answer
  sequence s_acc; i_psel && i_penable && !o_pready; endsequence
  // a start request seen while idle
  sequence s_go;
    s_acc ##0 (i_pwrite && i_paddr == OFF_CTRL &&
      i_pwdata[CTRL_GO_BIT] && !o_busy);
  endsequence
  // quiet spell: no instruction, no bus traffic
  sequence s_idle; (!o_busy && !i_psel) [*3]; endsequence
  property p_wait; s_acc |=> o_pready; endproperty
  a_wait: assert property (p_wait) else $error("late ready");
  property p_pulse; o_pready |=> !o_pready; endproperty
  a_pulse: assert property (p_pulse) else $error("ready too long");
  property p_err; o_pslverr |-> o_pready; endproperty
  a_err: assert property (p_err) else $error("error without ready");
  property p_bad; s_acc ##0 (i_paddr > OFF_MEM_DATA) |=> o_pslverr; endproperty
  a_bad: assert property (p_bad) else $error("unmapped accepted");
  property p_good;
    s_acc ##0 (i_paddr[1:0] == 2'h0 && i_paddr <= OFF_MEM_DATA) |=> !o_pslverr;
  endproperty
  a_good: assert property (p_good) else $error("mapped refused");
  property p_go; s_go |-> ##[1:4] o_busy; endproperty
  a_go: assert property (p_go) else $error("start lost");
  property p_bmin; $rose(o_busy) |-> o_busy [*3]; endproperty
  a_bmin: assert property (p_bmin) else $error("busy short");
  property p_bmax; $rose(o_busy) |-> ##[1:12] !o_busy; endproperty
  a_bmax: assert property (p_bmax) else $error("busy stuck");
  property p_pc; s_idle |=> $stable(o_pc); endproperty
  a_pc: assert property (p_pc) else $error("pc moved idle");
  property p_prod; s_idle |=> $stable(o_product); endproperty
  a_prod: assert property (p_prod) else $error("product moved");
endmodule // mnso_checker

/* multiply_negate_stack_ops_test.sv */
`timescale 1ns/10ps
module multiply_negate_stack_ops_test;
  import mnso_pkg::*;
  logic i_ref_clk, i_rst, i_psel, i_penable, i_pwrite, o_pready;
  logic o_pslverr, o_busy, er, a;
  logic [7:0] i_paddr, w, k, f, x;
  logic [31:0] i_pwdata, o_prdata, rd;
  logic [PC_W-1:0] o_pc, p;
  logic [15:0] o_product;
  logic [10:0] o;
  logic [3:0] bk;
  logic [31:0] sv [6];
  logic [7:0] rg [6] = '{OFF_PROD, OFF_STATUS, OFF_STACK_TOP, OFF_SP,
    OFF_WREG, OFF_PC};
  int fails, n_checks, cyc, n, n0, m;
  mnso_core i_dut (.i_ref_clk, .i_rst, .i_psel, .i_penable, .i_pwrite,
    .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_pc,
    .o_product, .o_busy);
  // bench clock
  initial begin
    i_ref_clk = 0;
    forever #10 i_ref_clk = ~i_ref_clk;
  end
  // hang guard, far above the fewer than two thousand cycles needed
  always @(posedge i_ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      summarize();
    end
  end
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("mismatch %s exp %h seen %h", nm, e, g);
    end
  endtask
  // one transfer, held until pready is sampled high
  task automatic apb(input logic wr, input logic [7:0] ad,
      input logic [31:0] d);
    @(posedge i_ref_clk);
    i_psel <= 1'h1;
    i_pwrite <= wr;
    i_paddr <= ad;
    i_pwdata <= d;
    @(posedge i_ref_clk);
    i_penable <= 1'h1;
    do @(posedge i_ref_clk); while (o_pready !== 1'h1);
    rd = o_prdata;
    er = o_pslverr;
    i_psel <= 1'h0;
    i_penable <= 1'h0;
  endtask
  task automatic rchk(input logic [7:0] ad, input logic [31:0] e);
    apb(1'h0, ad, 32'h0);
    chk($sformatf("reg %h", ad), e, rd);
  endtask
  task automatic mw(input logic [11:0] ad, input logic [7:0] b);
    apb(1'h1, OFF_MEM_ADDR, {20'h0, ad});
    apb(1'h1, OFF_MEM_DATA, {24'h0, b});
  endtask
  // load, start, count busy cycles
  task automatic run(input logic [15:0] op, output int c);
    apb(1'h1, OFF_INSTR, {16'h0, op});
    apb(1'h1, OFF_CTRL, 32'h1);
    c = 0;
    do @(posedge i_ref_clk); while (o_busy !== 1'h1);
    while (o_busy === 1'h1) begin
      @(posedge i_ref_clk);
      c++;
    end
    // quiet bus for a few cycles so the idle-time checks get to look
    repeat (4) @(posedge i_ref_clk);
  endtask
  function automatic logic [11:0] ea(logic s, logic [7:0] ff, logic [3:0] b);
    if (s)
      return {b, ff};
    return {(ff < ACCESS_SPLIT) ? 4'h0 : ACCESS_HI_BANK, ff};
  endfunction
  function automatic logic [31:0] nfl(logic [7:0] v);
    logic [7:0] r;
    r = 8'h0 - v;
    return {27'h0, r[7], v == 8'h80, r == 8'h0, v[3:0] == 4'h0, v == 8'h0};
  endfunction
  // main sequence
  initial begin
    i_rst = 1'h1;
    i_psel = 1'h0;
    i_penable = 1'h0;
    i_pwrite = 1'h0;
    i_paddr = 8'h0;
    i_pwdata = 32'h0;
    repeat (6) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    n = $urandom(23);
    foreach (rg[j]) rchk(rg[j], 32'h0);
    apb(1'h0, 8'h40, 32'h0);
    chk("slverr", 32'h1, {31'h0, er});
    rchk(OFF_CTRL, 32'h0);
    $display("done reset");
    // even passes literal, odd register with a decoy in the other bank
    for (int i = 0; i < 12; i++) begin
      w = (i == 0) ? 8'h0 : (i == 1) ? 8'hFF : 8'($urandom);
      k = (i == 1) ? 8'hFF : 8'($urandom);
      x = (i == 0) ? 8'h0 : 8'($urandom);
      {a, f, bk} = 13'($urandom);
      apb(1'h1, OFF_WREG, {24'h0, w});
      apb(1'h1, OFF_STATUS, {27'h0, x[4:0]});
      apb(1'h1, OFF_BANK, {28'h0, bk});
      if (i[0]) begin
        mw(ea(!a, f, bk), ~k);
        mw(ea(a, f, bk), k);
        run({OPC_MUL_REG, a, f}, n);
        rchk(OFF_MEM_DATA, {24'h0, k});
      end else
        run({OPC_MUL_LIT, k}, n);
      rchk(OFF_PROD, {16'h0, {8'h0, w} * {8'h0, k}});
      chk("product", {16'h0, {8'h0, w} * {8'h0, k}}, {16'h0, o_product});
      rchk(OFF_WREG, {24'h0, w});
      rchk(OFF_STATUS, {27'h0, x[4:0]});
    end
    $display("done multiply");
    for (int i = 0; i < 8; i++) begin
      x = (i == 0) ? 8'h0 : (i == 1) ? 8'h80 : (i == 2) ? 8'h10 : 8'($urandom);
      {a, f, bk} = 13'($urandom);
      apb(1'h1, OFF_BANK, {28'h0, bk});
      mw(ea(a, f, bk), x);
      run({OPC_NEG, a, f}, n);
      rchk(OFF_MEM_DATA, {24'h0, 8'h0 - x});
      rchk(OFF_STATUS, nfl(x));
    end
    $display("done negate");
    // two pushes, then pops past empty
    p = 21'($urandom) & 21'h1FFFFE;
    apb(1'h1, OFF_PC, {11'h0, p});
    run(OPC_PUSH, n);
    run(OPC_PUSH, n);
    rchk(OFF_STACK_TOP, {11'h0, p + 21'h4});
    rchk(OFF_SP, 32'h2);
    run(OPC_POP, n);
    rchk(OFF_STACK_TOP, {11'h0, p + 21'h2});
    rchk(OFF_SP, 32'h1);
    run(OPC_POP, n);
    run(OPC_POP, n);
    rchk(OFF_SP, 32'h0);
    rchk(OFF_PC, {11'h0, p + 21'hA});
    $display("done stack");
    // offset extremes first; call time against a plain no-op
    run(OPC_NOP0, n0);
    for (int i = 0; i < 4; i++) begin
      o = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'($urandom);
      p = 21'($urandom) & 21'h1FFFFE;
      apb(1'h1, OFF_PC, {11'h0, p});
      run({OPC_REL_CALL, o}, m);
      rchk(OFF_STACK_TOP, {11'h0, p + 21'h2});
      p = p + 21'h2 + {{9{o[10]}}, o, 1'h0};
      rchk(OFF_PC, {11'h0, p});
      chk("o_pc", {11'h0, p}, {11'h0, o_pc});
      chk("call cycles", n0 + 4, m);
    end
    $display("done call");
    for (int i = 0; i < 2; i++) begin
      foreach (rg[j]) begin
        apb(1'h0, rg[j], 32'h0);
        sv[j] = rd;
      end
      sv[5] = sv[5] + 32'h2;
      run(i ? {OPC_NOP_HI, 12'($urandom)} : OPC_NOP0, n);
      foreach (rg[j]) rchk(rg[j], sv[j]);
      chk("nop cycles", n0, n);
    end
    $display("done nop");
    apb(1'h1, OFF_BANK, 32'h5);
    apb(1'h1, OFF_WREG, 32'hA5);
    run(OPC_RESET, n);
    foreach (rg[j]) rchk(rg[j], 32'h0);
    rchk(OFF_BANK, 32'h0);
    $display("done soft reset");
    summarize();
  end
endmodule // multiply_negate_stack_ops_test
bind mnso_core mnso_checker i_chk (.i_ref_clk, .i_rst, .i_psel, .i_penable,
  .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .o_pc,
  .o_product, .o_busy);
